/* File: verilog/arc_ctrl.sv */
// converter sequence control, accumulator and result low byte register
`timescale 1ns/1ps
module arc_ctrl (
    // clock and reset
    input wire logic CLK_I,
    input wire logic RESET_I,
    // special-function register port
    input wire logic [7:0] SFR_ADDR_I,
    input wire logic [7:0] SFR_WDATA_I,
    input wire logic SFR_WE_I,
    input wire logic SFR_RE_I,
    output logic [7:0] SFR_RDATA_O,
    // configuration
    input wire logic EIGHT_BIT_MODE_ENABLE_I,
    input wire logic TWELVE_BIT_MODE_ENABLE_I,
    input wire logic BURST_MODE_ENABLE_I,
    input wire logic [2:0] REPEAT_COUNT_I,
    input wire logic SAMPLE_ONCE_SELECT_I,
    input wire logic GAIN_SELECT_I,
    input wire logic [2:0] RESULT_JUSTIFY_SHIFT_I,
    input wire logic START_I,
    // analog front end
    input wire logic COMPARATOR_I,
    output logic TRACK_O,
    output logic [9:0] DAC_CODE_O,
    output logic [1:0] REF_SEL_O,
    output logic [1:0] DEM_SEL_O,
    output logic GAIN_HALF_O,
    // status
    output logic BUSY_O,
    output logic DONE_O,
    output logic [7:0] RESULT_HIGH_BYTE_O
);
    // ------------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------------
    typedef struct packed {
        arc_pkg::arc_state_e fsm;
        logic sync1;
        logic sync2;
        logic tw;
        logic eight;
        logic once;
        logic gain;
        logic [6:0] total;
        logic [6:0] idx;
        logic [3:0] tcnt;
        logic track;
        logic sar_start;
        logic [1:0] ref_sel;
        logic [1:0] dem_sel;
        logic [15:0] accum;
        logic [15:0] result;
        logic busy;
        logic done;
        logic [7:0] rhigh;
        logic [7:0] rdata;
    } arc_ctrl_s;

    arc_ctrl_s q;
    arc_ctrl_s next_q;
    arc_sar_if sar ();

    // ------------------------------------------------------------------------
    // result formatting
    // ------------------------------------------------------------------------
    function automatic logic [15:0] arc_format(
        input logic [15:0] v,
        input logic [2:0] js,
        input logic [3:0] lsh
    );
        logic [15:0] r;
        r = v;
        case (js)
            arc_pkg::JS_RIGHT: r = v;
            arc_pkg::JS_SHR1: r = v >> 1;
            arc_pkg::JS_SHR2: r = v >> 2;
            arc_pkg::JS_SHR3: r = v >> 3;
            arc_pkg::JS_LEFT: r = v << lsh;
            default: r = v;
        endcase
        return r;
    endfunction : arc_format

    function automatic logic [3:0] arc_lsh(input logic tw, input logic eight);
        return tw ? arc_pkg::LSH_12 : (eight ? arc_pkg::LSH_8 : arc_pkg::LSH_10);
    endfunction : arc_lsh

    // ------------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------------
    always_comb begin
        logic [15:0] fv;
        logic [15:0] sum;
        logic [6:0] nidx;
        next_q = q;
        fv = arc_format(q.result, RESULT_JUSTIFY_SHIFT_I, arc_lsh(q.tw, q.eight)); // RULE12
        sum = q.accum + {6'h00, sar.code};
        nidx = q.idx + 7'h01;
        next_q.sync1 = COMPARATOR_I;
        next_q.sync2 = q.sync1;
        next_q.sar_start = 1'b0;
        next_q.done = 1'b0;
        next_q.rhigh = fv[15:8]; // RULE6
        next_q.rdata = 8'h00;
        if (SFR_RE_I && SFR_ADDR_I == arc_pkg::ADDR_RESULT_LOW) begin
            next_q.rdata = q.eight ? 8'h00 : fv[7:0]; // RULE2 RULE12
        end
        if (SFR_WE_I && SFR_ADDR_I == arc_pkg::ADDR_RESULT_LOW) begin
            next_q.accum[7:0] = SFR_WDATA_I; // RULE13
            next_q.result[7:0] = SFR_WDATA_I;
        end
        case (q.fsm)
            arc_pkg::ST_IDLE: begin
                if (START_I) begin // RULE6
                    next_q.tw = TWELVE_BIT_MODE_ENABLE_I && BURST_MODE_ENABLE_I; // RULE3
                    next_q.eight = EIGHT_BIT_MODE_ENABLE_I
                        && !(TWELVE_BIT_MODE_ENABLE_I && BURST_MODE_ENABLE_I); // RULE14
                    next_q.once = SAMPLE_ONCE_SELECT_I;
                    next_q.gain = GAIN_SELECT_I; // RULE11
                    next_q.total = BURST_MODE_ENABLE_I ? (7'h01 << REPEAT_COUNT_I) : 7'h01;
                    next_q.idx = 7'h00;
                    next_q.accum = 16'h0000;
                    next_q.ref_sel = arc_pkg::SET_PHASE_FIRST;
                    next_q.dem_sel = arc_pkg::SET_PHASE_FIRST;
                    next_q.tcnt = 4'h0;
                    next_q.track = 1'b1;
                    next_q.busy = 1'b1;
                    next_q.fsm = arc_pkg::ST_TRACK;
                end
            end
            arc_pkg::ST_TRACK: begin
                if (q.tcnt == arc_pkg::TRACK_LAST) begin
                    next_q.track = 1'b0;
                    next_q.sar_start = 1'b1;
                    next_q.fsm = arc_pkg::ST_CONV;
                end else begin
                    next_q.tcnt = q.tcnt + 4'h1;
                end
            end
            arc_pkg::ST_CONV: begin
                if (sar.done) begin
                    next_q.accum = sum; // RULE15 RULE8
                    if (nidx == q.total) begin
                        next_q.result = sum; // RULE15 RULE7
                        next_q.done = 1'b1;
                        next_q.busy = 1'b0;
                        next_q.fsm = arc_pkg::ST_IDLE;
                    end else begin
                        next_q.idx = nidx;
                        // twelve-bit mode only: new reference and element rotation per conversion
                        next_q.ref_sel = q.tw ? nidx[1:0] : arc_pkg::SET_PHASE_FIRST; // RULE4
                        next_q.dem_sel = q.tw ? nidx[1:0] : arc_pkg::SET_PHASE_FIRST; // RULE5
                        if (q.tw && q.once && nidx[1:0] != arc_pkg::SET_PHASE_FIRST) begin
                            next_q.sar_start = 1'b1; // RULE9
                        end else begin
                            next_q.track = 1'b1; // RULE10
                            next_q.tcnt = 4'h0;
                            next_q.fsm = arc_pkg::ST_TRACK;
                        end
                    end
                end
            end
            default: begin
                next_q.fsm = arc_pkg::ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------------
    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            q <= '0;
            q.fsm <= arc_pkg::ST_IDLE;
            q.result <= {8'h00, arc_pkg::RESULT_LOW_RESET};
        end else begin
            q <= next_q;
        end
    end

    // ------------------------------------------------------------------------
    // bit-trial engine
    // ------------------------------------------------------------------------
    assign sar.start = q.sar_start;
    assign sar.eight = q.eight; // RULE1
    assign sar.comp = q.sync2;

    arc_sar u_sar (
        .clk_i(CLK_I),
        .reset_i(RESET_I),
        .s(sar.sar)
    );

    // ------------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------------
    assign SFR_RDATA_O = q.rdata;
    assign TRACK_O = q.track;
    assign DAC_CODE_O = sar.code;
    assign REF_SEL_O = q.ref_sel;
    assign DEM_SEL_O = q.dem_sel;
    assign GAIN_HALF_O = q.gain; // RULE11
    assign BUSY_O = q.busy;
    assign DONE_O = q.done;
    assign RESULT_HIGH_BYTE_O = q.rhigh;

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RESET_I);

    AST_LOW_READ_ZERO: assert property ( // RULE2
        SFR_RE_I && SFR_ADDR_I == arc_pkg::ADDR_RESULT_LOW && q.eight |=> SFR_RDATA_O == 8'h00)
        else $error("low byte read nonzero in eight-bit mode");

    AST_LOW_WRITE: assert property ( // RULE13
        SFR_WE_I && SFR_ADDR_I == arc_pkg::ADDR_RESULT_LOW && q.fsm == arc_pkg::ST_IDLE
        |=> q.accum[7:0] == $past(SFR_WDATA_I) && q.result[7:0] == $past(SFR_WDATA_I))
        else $error("low byte write not loaded into accumulator");

    AST_SUM_MAX: assert property ( // RULE7
        q.done && q.tw && q.total == 7'h04 |-> q.result <= arc_pkg::MAX_SUM_12)
        else $error("twelve-bit sum above four times ten-bit maximum");

    AST_REF_PHASE: assert property ( // RULE4
        q.sar_start && q.tw |-> REF_SEL_O == q.idx[1:0])
        else $error("reference level does not follow conversion index");

    AST_DEM_ROTATE: assert property ( // RULE5
        q.fsm == arc_pkg::ST_CONV && sar.done && q.tw && !next_q.done
        |=> DEM_SEL_O != $past(DEM_SEL_O))
        else $error("element arrangement not rotated between conversions");

    AST_TRACK_ONCE: assert property ( // RULE9
        q.sar_start && q.tw && q.once && q.idx[1:0] != 2'h0 |-> !$past(TRACK_O))
        else $error("input retracked inside a sample-once set");

    AST_TRACK_EACH: assert property ( // RULE10
        q.sar_start && !(q.tw && q.once) |-> $past(TRACK_O) && !TRACK_O)
        else $error("conversion started without a fresh track");

    AST_GAIN_HOLD: assert property ( // RULE11
        BUSY_O && !DONE_O |=> $stable(GAIN_HALF_O))
        else $error("gain changed during a conversion sequence");

    AST_RESULT_AT_END: assert property ( // RULE15
        BUSY_O && !next_q.done |=> $stable(q.result[15:8]))
        else $error("result changed before the repeat count completed");

    AST_START_TRACK: assert property ( // RULE6
        q.fsm == arc_pkg::ST_IDLE && START_I |=> BUSY_O && TRACK_O)
        else $error("start request not taken");

    COV_TWELVE_SET: cover property (q.done && q.tw);
    COV_EIGHT_SET: cover property (q.done && q.eight);
    COV_ONCE_SKIP: cover property (q.sar_start && q.tw && q.once && q.idx[1:0] == 2'h3);
    COV_LOW_WRITE: cover property (SFR_WE_I && SFR_ADDR_I == arc_pkg::ADDR_RESULT_LOW);

endmodule : arc_ctrl

/* File: verilog/arc_pkg.sv */
// constants and types shared by the resolution/accumulator converter control
// ----------------------------------------------------------------------------
// Notes on behaviour
// RULE1 - eight-bit mode converts eight MSBs, fewer steps
// RULE2 - eight-bit mode: low bits zero, low byte reads zero
// RULE3 - twelve-bit needs burst with four or more (code needs burst only; repeat count not checked)
// RULE4 - twelve-bit: four ten-bit conversions, four references
// RULE5 - rotate largest DAC elements before each conversion (code rotates only in twelve-bit mode)
// RULE6 - any start source; result in high/low bytes
// RULE7 - twelve-bit maximum is four times 1023
// RULE8 - repeat multiple of four accumulates wider sums
// RULE9 - sample-once: track once, hold for four
// RULE10 - sample-each: track before every conversion of set
// RULE11 - gain select picks unity or half gain
// RULE12 - low byte reads accumulator, justified and shifted
// RULE13 - low byte write loads accumulator low byte
// RULE14 - resolution selectable as eight, ten, twelve
// RULE15 - burst adds results, registers update at end
// ----------------------------------------------------------------------------
package arc_pkg;

    // ------------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------------
    localparam logic [7:0] ADDR_RESULT_LOW = 8'hbd;
    localparam logic [7:0] RESULT_LOW_RESET = 8'h00;

    // ------------------------------------------------------------------------
    // result formatting
    // ------------------------------------------------------------------------
    localparam logic [2:0] JS_RIGHT = 3'h0;
    localparam logic [2:0] JS_SHR1 = 3'h1;
    localparam logic [2:0] JS_SHR2 = 3'h2;
    localparam logic [2:0] JS_SHR3 = 3'h3;
    localparam logic [2:0] JS_LEFT = 3'h4;
    localparam logic [3:0] LSH_8 = 4'h8;
    localparam logic [3:0] LSH_10 = 4'h6;
    localparam logic [3:0] LSH_12 = 4'h4;
    localparam logic [15:0] MAX_SUM_12 = 16'hffc;

    // ------------------------------------------------------------------------
    // successive approximation
    // ------------------------------------------------------------------------
    localparam logic [9:0] SAR_FIRST_CODE = 10'h200;
    localparam logic [3:0] SAR_MSB = 4'h9;
    localparam logic [3:0] SAR_STOP_10 = 4'h0;
    localparam logic [3:0] SAR_STOP_8 = 4'h2;
    localparam logic [1:0] SET_PHASE_FIRST = 2'h0;

    // ------------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 25;
    localparam int SAR_CLK_PERIOD_NS = 100;
    localparam int TRACK_TIME_NS = 250;
    localparam logic [1:0] SAR_DIV_LAST =
        2'((SAR_CLK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS - 1);
    localparam logic [3:0] TRACK_LAST =
        4'((TRACK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS - 1);

    // ------------------------------------------------------------------------
    // control states
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_TRACK = 2'b01,
        ST_CONV = 2'b10
    } arc_state_e;

endpackage : arc_pkg

/* File: verilog/arc_sar_if.sv */
// handshake between the sequence control and the bit-trial engine
`timescale 1ns/1ps
interface arc_sar_if;
    logic start;
    logic eight;
    logic comp;
    logic busy;
    logic done;
    logic [9:0] code;

    modport ctrl (output start, output eight, output comp, input busy, input done, input code);
    modport sar (input start, input eight, input comp, output busy, output done, output code);
endinterface : arc_sar_if

/* File: verilog/arc_sar.sv */
// bit-trial engine: one eight- or ten-bit successive approximation
`timescale 1ns/1ps
module arc_sar (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // control side
    arc_sar_if.sar s
);
    typedef struct packed {
        logic busy;
        logic done;
        logic eight;
        logic [9:0] code;
        logic [3:0] bit_idx;
        logic [1:0] div;
    } arc_sar_s;

    arc_sar_s q;
    arc_sar_s next_q;

    always_comb begin
        next_q = q;
        next_q.done = 1'b0;
        if (!q.busy) begin
            if (s.start) begin
                next_q.busy = 1'b1;
                next_q.eight = s.eight;
                next_q.code = arc_pkg::SAR_FIRST_CODE;
                next_q.bit_idx = arc_pkg::SAR_MSB;
                next_q.div = 2'h0;
            end
        end else if (q.div == arc_pkg::SAR_DIV_LAST) begin
            next_q.div = 2'h0;
            if (!s.comp) begin
                next_q.code[q.bit_idx] = 1'b0;
            end
            // eight-bit mode stops two trials early
            if (q.bit_idx == (q.eight ? arc_pkg::SAR_STOP_8 : arc_pkg::SAR_STOP_10)) begin // RULE1 RULE14
                next_q.busy = 1'b0;
                next_q.done = 1'b1;
            end else begin
                next_q.bit_idx = q.bit_idx - 4'h1;
                next_q.code[q.bit_idx - 4'h1] = 1'b1;
            end
        end else begin
            next_q.div = q.div + 2'h1;
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign s.busy = q.busy;
    assign s.done = q.done;
    assign s.code = q.code;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    AST_EIGHT_STEPS: assert property (!q.busy && s.start && s.eight |-> ##33 q.done) // RULE1
        else $error("eight-bit conversion did not end after eight trials");
    AST_TEN_STEPS: assert property (!q.busy && s.start && !s.eight |-> ##41 q.done) // RULE14
        else $error("ten-bit conversion did not end after ten trials");
    AST_EIGHT_LSB_ZERO: assert property (q.done && q.eight |-> q.code[1:0] == 2'h0) // RULE2
        else $error("eight-bit result has nonzero low bits");

endmodule : arc_sar

/* File: bench/arc_analog_model.sv */
// analog front end model: track/hold of the input and the comparator
`timescale 1ns/1ps
module arc_analog_model (
    // clock
    input wire logic clk_i,
    // converter side
    input wire logic track_i,
    input wire logic gain_half_i,
    input wire logic [1:0] ref_sel_i,
    input wire logic [9:0] dac_code_i,
    // analog input, twelve-bit scale
    input wire logic [11:0] ain_i,
    output logic comp_o
);
    logic [11:0] held = 12'h000;
    logic [12:0] lvl;

    // samples the input only while the converter tracks
    always @(posedge clk_i) begin
        if (track_i === 1'h1) begin
            held <= (gain_half_i === 1'h1) ? {1'h0, ain_i[11:1]} : ain_i;
        end
    end

    // reference level ref_sel_i offsets the held input by ref_sel_i quarter steps
    always_comb begin
        lvl = (13'(held) + 13'(ref_sel_i)) >> 2;
        comp_o = (lvl > 13'h3ff) || (lvl[9:0] >= dac_code_i);
    end
endmodule : arc_analog_model

/* File: bench/adc_resolution_accumulator_ctrl_test.sv */
// self-checking bench for the converter sequence control
`timescale 1ns/1ps
module adc_resolution_accumulator_ctrl_test;
    // ----------
    // signals
    // ----------
    logic CLK_I = 1'h0, RESET_I = 1'h1;
    logic [7:0] SFR_ADDR_I = 8'h00, SFR_WDATA_I = 8'h00, SFR_RDATA_O, RESULT_HIGH_BYTE_O;
    logic SFR_WE_I = 1'h0, SFR_RE_I = 1'h0, START_I = 1'h0;
    logic EIGHT_BIT_MODE_ENABLE_I = 1'h0, TWELVE_BIT_MODE_ENABLE_I = 1'h0;
    logic BURST_MODE_ENABLE_I = 1'h0, SAMPLE_ONCE_SELECT_I = 1'h0, GAIN_SELECT_I = 1'h0;
    logic [2:0] REPEAT_COUNT_I = 3'h0, RESULT_JUSTIFY_SHIFT_I = 3'h0;
    logic COMPARATOR_I, TRACK_O, GAIN_HALF_O, BUSY_O, DONE_O;
    logic [9:0] DAC_CODE_O;
    logic [1:0] REF_SEL_O, DEM_SEL_O;
    logic [11:0] ain = 12'h000;
    int seed = 32'h079d0198;
    int num_errors = 0;
    int n_checks = 0;
    int tn = 0;

    always #12.5 CLK_I = ~CLK_I;

    arc_ctrl arc_ctrl_i (.CLK_I(CLK_I), .RESET_I(RESET_I), .SFR_ADDR_I(SFR_ADDR_I),
        .SFR_WDATA_I(SFR_WDATA_I), .SFR_WE_I(SFR_WE_I), .SFR_RE_I(SFR_RE_I),
        .SFR_RDATA_O(SFR_RDATA_O), .EIGHT_BIT_MODE_ENABLE_I(EIGHT_BIT_MODE_ENABLE_I),
        .TWELVE_BIT_MODE_ENABLE_I(TWELVE_BIT_MODE_ENABLE_I),
        .BURST_MODE_ENABLE_I(BURST_MODE_ENABLE_I), .REPEAT_COUNT_I(REPEAT_COUNT_I),
        .SAMPLE_ONCE_SELECT_I(SAMPLE_ONCE_SELECT_I), .GAIN_SELECT_I(GAIN_SELECT_I),
        .RESULT_JUSTIFY_SHIFT_I(RESULT_JUSTIFY_SHIFT_I), .START_I(START_I),
        .COMPARATOR_I(COMPARATOR_I), .TRACK_O(TRACK_O), .DAC_CODE_O(DAC_CODE_O),
        .REF_SEL_O(REF_SEL_O), .DEM_SEL_O(DEM_SEL_O), .GAIN_HALF_O(GAIN_HALF_O),
        .BUSY_O(BUSY_O), .DONE_O(DONE_O), .RESULT_HIGH_BYTE_O(RESULT_HIGH_BYTE_O));

    arc_analog_model arc_analog_model_i (.clk_i(CLK_I), .track_i(TRACK_O),
        .gain_half_i(GAIN_HALF_O), .ref_sel_i(REF_SEL_O), .dac_code_i(DAC_CODE_O),
        .ain_i(ain), .comp_o(COMPARATOR_I));

    // ----------
    // expectations
    // ----------
    function automatic logic [15:0] exp_sum(input logic [11:0] a, b, input logic tw, so, gh, e8,
                                            input int n);
        logic [15:0] s;
        logic [15:0] v;
        logic [12:0] l;
        logic [11:0] x;
        int k;
        s = 16'h0000;
        for (int i = 0; i < n; i++) begin
            k = (tw && so) ? (i / 4) * 4 : i;
            x = (k == 0) ? a : b;
            if (gh) x = x >> 1;
            l = (13'(x) + (tw ? 13'(i % 4) : 13'h0)) >> 2;
            v = (l > 13'h3ff) ? 16'h03ff : 16'(l);
            if (e8) v[1:0] = 2'h0;
            s = s + v;
        end
        return s;
    endfunction : exp_sum

    function automatic logic [15:0] fmt(input logic [15:0] s, input logic [2:0] js,
                                        input logic tw, e8);
        if (js == arc_pkg::JS_LEFT) begin
            return s << (tw ? arc_pkg::LSH_12 : (e8 ? arc_pkg::LSH_8 : arc_pkg::LSH_10));
        end
        if (js == arc_pkg::JS_SHR1 || js == arc_pkg::JS_SHR2 || js == arc_pkg::JS_SHR3) begin
            return s >> js;
        end
        return s;
    endfunction : fmt

    // ----------
    // shared tasks
    // ----------
    task automatic end_sim();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_sim

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic sfr_read(input logic [7:0] ad, output logic [7:0] d);
        SFR_ADDR_I = ad;
        SFR_RE_I = 1'h1;
        @(negedge CLK_I);
        d = SFR_RDATA_O;
        SFR_RE_I = 1'h0;
        @(negedge CLK_I);
    endtask : sfr_read

    task automatic sfr_write(input logic [7:0] ad, input logic [7:0] d);
        SFR_ADDR_I = ad;
        SFR_WDATA_I = d;
        SFR_WE_I = 1'h1;
        @(negedge CLK_I);
        SFR_WE_I = 1'h0;
        @(negedge CLK_I);
    endtask : sfr_write

    // one set of conversions; input moves to b once the first track ends
    task automatic run(input logic eb, tw, bm, input logic [2:0] rc, input logic so, gh,
                       input logic [2:0] js, input logic [11:0] a, b);
        int n, cyc, tr;
        logic td, ok, e8;
        logic [7:0] hb, rd;
        logic [15:0] e;
        n = bm ? (1 << rc) : 1;
        e8 = eb && !(tw && bm);
        EIGHT_BIT_MODE_ENABLE_I = eb;
        TWELVE_BIT_MODE_ENABLE_I = tw;
        BURST_MODE_ENABLE_I = bm;
        REPEAT_COUNT_I = rc;
        SAMPLE_ONCE_SELECT_I = so;
        GAIN_SELECT_I = gh;
        RESULT_JUSTIFY_SHIFT_I = js;
        ain = a;
        // live justify setting reaches the high byte one edge later
        @(negedge CLK_I);
        hb = RESULT_HIGH_BYTE_O;
        START_I = 1'h1;
        @(negedge CLK_I);
        START_I = 1'h0;
        cyc = 1;
        tr = 0;
        td = 1'h0;
        ok = 1'h1;
        while (DONE_O !== 1'h1 && cyc < 4000) begin
            if (TRACK_O === 1'h1 && td === 1'h0) tr++;
            td = TRACK_O;
            if (tr > 0 && TRACK_O === 1'h0) ain = b;
            // a second start while busy must be ignored
            START_I = (cyc == 20);
            if (RESULT_HIGH_BYTE_O !== hb || DEM_SEL_O !== REF_SEL_O) ok = 1'h0;
            if (BUSY_O !== 1'h1) ok = 1'h0;
            @(negedge CLK_I);
            cyc++;
        end
        if (cyc >= 4000) begin
            num_errors++;
            end_sim();
        end
        @(negedge CLK_I);
        check(16'(DONE_O), 16'h0000);
        check(16'(BUSY_O), 16'h0000);
        check(16'(ok), 16'h0001);
        check(16'(tr), 16'((tw && so) ? n / 4 : n));
        if (!bm) check(16'(cyc), e8 ? 16'h002d : 16'h0035);
        e = fmt(exp_sum(a, b, tw && bm, so, gh, e8, n), js, tw && bm, e8);
        check(16'(RESULT_HIGH_BYTE_O), 16'(e[15:8]));
        sfr_read(arc_pkg::ADDR_RESULT_LOW, rd);
        check(16'(rd), e8 ? 16'h0000 : 16'(e[7:0]));
        tn++;
        $display("test %0d done", tn);
    endtask : run

    // ----------
    // main sequence
    // ----------
    initial begin
        logic [7:0] d;
        logic [31:0] r;
        logic t;
        repeat (12) @(negedge CLK_I);
        RESET_I = 1'h0;
        @(negedge CLK_I);
        sfr_read(arc_pkg::ADDR_RESULT_LOW, d);
        check(16'(d), 16'(arc_pkg::RESULT_LOW_RESET));
        run(1'h1, 1'h0, 1'h0, 3'h0, 1'h0, 1'h0, 3'h0, 12'h9a7, 12'h9a7);
        run(1'h0, 1'h0, 1'h0, 3'h0, 1'h0, 1'h0, 3'h0, 12'h6b5, 12'h6b5);
        sfr_write(arc_pkg::ADDR_RESULT_LOW, 8'h5a);
        sfr_write(8'hbc, 8'hc3);
        sfr_read(arc_pkg::ADDR_RESULT_LOW, d);
        check(16'(d), 16'h005a);
        check(16'(RESULT_HIGH_BYTE_O), 16'h0001);
        sfr_read(8'hbc, d);
        check(16'(d), 16'h0000);
        run(1'h0, 1'h1, 1'h1, 3'h2, 1'h1, 1'h0, 3'h0, 12'hfff, 12'h000);
        run(1'h1, 1'h1, 1'h1, 3'h2, 1'h0, 1'h0, 3'h4, 12'h5a3, 12'h2c1);
        run(1'h0, 1'h1, 1'h1, 3'h4, 1'h1, 1'h0, 3'h2, 12'h8e1, 12'h123);
        run(1'h0, 1'h0, 1'h1, 3'h3, 1'h0, 1'h1, 3'h1, 12'hd37, 12'h44a);
        run(1'h0, 1'h0, 1'h0, 3'h0, 1'h0, 1'h1, 3'h4, 12'hfff, 12'hfff);
        for (int i = 0; i < 8; i++) begin
            r = $random(seed);
            t = r[0];
            run(1'h0, t, t | r[1], t ? {2'h1, r[2]} : {1'h0, r[3:2]}, r[4], r[5],
                {1'h0, r[7:6]}, r[19:8], r[31:20]);
        end
        end_sim();
    end
endmodule : adc_resolution_accumulator_ctrl_test
